// file: rtl/pdiv_pkg.sv
package pdiv_pkg;

  // ---------------------------------------------------------------
  // structure
  // ---------------------------------------------------------------
  localparam int N_ENGINE = 4;
  localparam int N_PER    = 4;
  localparam int N_CH     = N_ENGINE * N_PER;
  localparam int N_BANK   = 2;
  localparam int N_SLEW   = 12;
  localparam int GPIO_W   = 10;
  localparam int RATIO_W  = 23;
  localparam int SKEW_W   = 16;
  localparam int FINE_W   = 4;
  localparam int PIN_W    = 4;
  localparam int CFGW_W   = 25;
  localparam int ADR_W    = 8;
  localparam int SUB_HPSE = 2;
  localparam int SUB_CFG  = 3;

  // ---------------------------------------------------------------
  // frequencies in kHz
  // ---------------------------------------------------------------
  localparam int ENG_PREC_KHZ      = 1500000;
  localparam int ENG_GEN_KHZ       = 750000;
  localparam int N_PREC_ENG        = 2;
  localparam int F_HPDIFF_MAX_KHZ  = 750000;
  localparam int F_HPSE_MAX_KHZ    = 177500;
  localparam int F_CFGSE_MAX_KHZ   = 160000;
  localparam int F_CFGDIFF_MAX_KHZ = 350000;
  localparam int F_MIN_KHZ         = 1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int STRAP_MS       = 50;
  localparam int POR_MIN_MS     = 2;
  localparam int STRAP_CYCLES   = STRAP_MS * 1000 * CLK_MHZ;
  localparam int STRAP_CNT_W    = 23;

  // ---------------------------------------------------------------
  // strap codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MCLK_CODE_24M576 = 2'h3;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [ADR_W-1:0] REG_CH_EN  = 8'h00;
  localparam logic [ADR_W-1:0] REG_STOP   = 8'h04;
  localparam logic [ADR_W-1:0] REG_OUTCFG = 8'h08;
  localparam logic [ADR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADR_W-1:0] REG_CH_SEL = 8'h10;
  localparam logic [ADR_W-1:0] REG_RATIO  = 8'h14;
  localparam logic [ADR_W-1:0] REG_SKEW   = 8'h18;

  localparam int STOP_EDGE_LSB = 16;
  localparam int OC_FINE_BIT   = 2;
  localparam int OC_SLEW_LSB   = 16;
  localparam int ST_CODE_LSB   = 1;
  localparam int ST_OK_BIT     = 3;
  localparam int ST_RUN_LSB    = 16;
  localparam int SK_FINE_LSB   = 16;
  localparam int SK_PIN_LSB    = 20;
  localparam int SK_PEN_BIT    = 24;

  localparam logic [RATIO_W-1:0] RATIO_RST = 23'h000002;

endpackage

// file: rtl/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
  import pdiv_pkg::*;
  logic               tick;
  logic               en;
  logic               stop;
  logic               edge_rise;
  logic [RATIO_W-1:0] ratio;
  logic [SKEW_W-1:0]  skew;
  logic               clk_out;
  logic               running;

  modport ctl  (output tick, en, stop, edge_rise, ratio, skew, input clk_out, running);
  modport chan (input tick, en, stop, edge_rise, ratio, skew, output clk_out, running);
endinterface

// file: rtl/pdiv_channel.sv
`timescale 1ns/1ps
module pdiv_channel
  import pdiv_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // channel control
  chan_if.chan      ch
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SKEW = 2'b01,
    ST_RUN  = 2'b11,
    ST_HELD = 2'b10
  } chan_state_t;

  chan_state_t        state;
  logic [RATIO_W-1:0] cnt;
  logic               out;

  wire [RATIO_W-1:0] len_lo   = ch.ratio >> 1;
  wire [RATIO_W-1:0] len_hi   = ch.ratio - len_lo;
  wire [RATIO_W-1:0] len      = out ? len_hi : len_lo;
  wire [RATIO_W-1:0] cnt_inc  = cnt + 1'b1;
  wire [RATIO_W-1:0] skew_ext = {{(RATIO_W - SKEW_W){1'b0}}, ch.skew};
  wire               halt     = ch.stop || !ch.en;
  wire               phase_end = cnt_inc >= len;
  // the toggle about to happen is the edge chosen for the stop
  wire               stop_hit = ch.stop && (out ? !ch.edge_rise : ch.edge_rise);

  // ---------------------------------------------------------------
  // divider state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cnt   <= '0;
      out   <= 1'b0;
    end else if (ce_i && ch.tick) begin
      unique case (state)
        ST_IDLE: begin
          if (!halt) begin
            cnt   <= '0;
            state <= ST_SKEW;
          end
        end
        ST_SKEW: begin
          if (halt) begin
            state <= ST_IDLE;
          end else if (cnt >= skew_ext) begin
            cnt   <= '0;
            out   <= 1'b1;
            state <= ST_RUN;
          end else begin
            cnt <= cnt_inc;
          end
        end
        ST_RUN: begin
          if (phase_end) begin
            cnt <= '0;
            out <= !out;
            if (!ch.en && out) begin
              state <= ST_IDLE;
            end else if (stop_hit) begin
              state <= ST_HELD;
            end
          end else begin
            cnt <= cnt_inc;
          end
        end
        ST_HELD: begin
          if (!ch.en) begin
            out   <= 1'b0;
            state <= ST_IDLE;
          end else if (!ch.stop) begin
            cnt   <= '0;
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign ch.clk_out = out;
  assign ch.running = (state == ST_RUN);

endmodule

// file: rtl/pdiv_strap.sv
`timescale 1ns/1ps
module pdiv_strap
  import pdiv_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES = STRAP_CYCLES
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // synchronised pins
  input  wire logic       pwr_ok_i,
  input  wire logic [1:0] strap_i,
  // result
  output logic            done_o,
  output logic [1:0]      code_o,
  output logic            mclk_ok_o
);

  localparam logic [STRAP_CNT_W-1:0] WIN_LAST = STRAP_CNT_W'(WINDOW_CYCLES - 1);

  logic [STRAP_CNT_W-1:0] cnt;

  // ---------------------------------------------------------------
  // strap window
  // ---------------------------------------------------------------
  // window restarts while power-on reset is low
  always_ff @(posedge clk_i) begin
    if (rst_i || !pwr_ok_i) begin
      cnt       <= '0;
      done_o    <= 1'b0;
      code_o    <= 2'h0;
      mclk_ok_o <= 1'b0;
    end else if (ce_i && !done_o) begin
      // sample at the end of the hold time
      if (cnt == WIN_LAST) begin
        done_o <= 1'b1;
        code_o <= strap_i;
        // only code 3 is a valid master clock
        mclk_ok_o <= (strap_i == MCLK_CODE_24M576);
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

// file: rtl/pdiv_skew_ctrl.sv
`timescale 1ns/1ps
module pdiv_skew_ctrl
  import pdiv_pkg::*;
#(
  parameter int unsigned STRAP_WINDOW_CYCLES = STRAP_CYCLES
)
(
  // clock, reset, enable
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [ADR_W-1:0]         wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // synthesizer high-speed clock enables
  input  wire logic [N_ENGINE-1:0]      synth_tick_i,
  // pins
  input  wire logic                     pwr_n_i,
  input  wire logic [GPIO_W-1:0]        gpio_i,
  // divided clocks and driver settings
  output logic      [N_CH-1:0]          pdiv_clk_o,
  output logic      [N_CH*FINE_W-1:0]   fine_skew_o,
  output logic      [N_BANK-1:0]        bank_diff_o,
  output logic      [N_SLEW-1:0]        slew_fast_o,
  // start-up status
  output logic                          strap_done_o,
  output logic      [1:0]               mclk_code_o,
  output logic                          mclk_ok_o
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [N_CH-1:0]    ch_en;
  logic [N_CH-1:0]    stop_req;
  logic [N_CH-1:0]    stop_rise;
  logic [N_BANK-1:0]  bank_diff;
  logic               fine_en;
  logic [N_SLEW-1:0]  slew_fast;
  logic [PIN_W-1:0]   ch_sel;
  logic [RATIO_W-1:0] ratio_mem [N_CH];
  logic [CFGW_W-1:0]  skew_mem  [N_CH];
  logic [N_CH-1:0]    running;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [GPIO_W:0] pin_meta;
  logic [GPIO_W:0] pin_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce_i) begin
      pin_meta <= {pwr_n_i, gpio_i};
      pin_sync <= pin_meta;
    end
  end

  wire [GPIO_W-1:0] gpio_s = pin_sync[GPIO_W-1:0];
  wire              pwr_ok = pin_sync[GPIO_W];

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  pdiv_strap #(
    .WINDOW_CYCLES (STRAP_WINDOW_CYCLES)
  ) u_strap (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .pwr_ok_i  (pwr_ok),
    .strap_i   (gpio_s[1:0]),
    .done_o    (strap_done_o),
    .code_o    (mclk_code_o),
    .mclk_ok_o (mclk_ok_o)
  );

  // strap pins free for gpio after the window
  wire [GPIO_W-1:0] gpio_usable = {{(GPIO_W - 2){1'b1}}, {2{strap_done_o}}};
  wire [GPIO_W-1:0] gpio_live   = gpio_s & gpio_usable;

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  wire req     = wb_cyc_i && wb_stb_i;
  wire wr_fire = req && wb_we_i && wb_ack_o;
  wire hit_en  = wb_adr_i == REG_CH_EN;
  wire hit_stp = wb_adr_i == REG_STOP;
  wire hit_oc  = wb_adr_i == REG_OUTCFG;
  wire hit_st  = wb_adr_i == REG_STATUS;
  wire hit_sel = wb_adr_i == REG_CH_SEL;
  wire hit_rat = wb_adr_i == REG_RATIO;
  wire hit_skw = wb_adr_i == REG_SKEW;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] cur_en  = {16'h0000, ch_en};
  wire [31:0] cur_stp = {stop_rise, stop_req};
  wire [31:0] cur_oc  = {4'h0, slew_fast, 13'h0000, fine_en, bank_diff};
  wire [31:0] cur_st  = {running, 12'h000, mclk_ok_o, mclk_code_o, strap_done_o};
  wire [31:0] cur_sel = {28'h0000000, ch_sel};
  wire [31:0] cur_rat = {9'h000, ratio_mem[ch_sel]};
  wire [31:0] cur_skw = {7'h00, skew_mem[ch_sel]};

  wire [31:0] new_en  = merge(cur_en,  wb_dat_i, wb_sel_i);
  wire [31:0] new_stp = merge(cur_stp, wb_dat_i, wb_sel_i);
  wire [31:0] new_oc  = merge(cur_oc,  wb_dat_i, wb_sel_i);
  wire [31:0] new_sel = merge(cur_sel, wb_dat_i, wb_sel_i);
  wire [31:0] new_rat = merge(cur_rat, wb_dat_i, wb_sel_i);
  wire [31:0] new_skw = merge(cur_skw, wb_dat_i, wb_sel_i);

  wire [31:0] rd_mux = hit_en  ? cur_en  :
                       hit_stp ? cur_stp :
                       hit_oc  ? cur_oc  :
                       hit_st  ? cur_st  :
                       hit_sel ? cur_sel :
                       hit_rat ? cur_rat :
                       hit_skw ? cur_skw : 32'h00000000;

  // ---------------------------------------------------------------
  // wishbone answer
  // ---------------------------------------------------------------
  wire take    = req && !wb_ack_o;
  wire rd_take = take && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= take;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_dat_o <= rd_take ? rd_mux : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------
  wire we_en  = ce_i && wr_fire && hit_en;
  wire we_stp = ce_i && wr_fire && hit_stp;
  wire we_oc  = ce_i && wr_fire && hit_oc;
  wire we_sel = ce_i && wr_fire && hit_sel;
  wire we_rat = ce_i && wr_fire && hit_rat;
  wire we_skw = ce_i && wr_fire && hit_skw;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_en <= '0;
    end else if (we_en) begin
      ch_en <= new_en[N_CH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_req  <= '0;
      stop_rise <= '0;
    end else if (we_stp) begin
      stop_req  <= new_stp[N_CH-1:0];
      stop_rise <= new_stp[STOP_EDGE_LSB +: N_CH];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_diff <= '0;
      fine_en   <= 1'b0;
      slew_fast <= '0;
    end else if (we_oc) begin
      bank_diff <= new_oc[N_BANK-1:0];
      fine_en   <= new_oc[OC_FINE_BIT];
      slew_fast <= new_oc[OC_SLEW_LSB +: N_SLEW];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_sel <= '0;
    end else if (we_sel) begin
      ch_sel <= new_sel[PIN_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_CH; i++) begin
        ratio_mem[i] <= RATIO_RST;
      end
    end else if (we_rat) begin
      ratio_mem[ch_sel] <= new_rat[RATIO_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_CH; i++) begin
        skew_mem[i] <= '0;
      end
    end else if (we_skw) begin
      skew_mem[ch_sel] <= new_skw[CFGW_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // driver settings
  // ---------------------------------------------------------------
  assign bank_diff_o = bank_diff;
  assign slew_fast_o = slew_fast;

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  // four channels per engine
  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    localparam int ENG  = g / N_PER;
    localparam int SUB  = g % N_PER;
    localparam int EKHZ = (ENG < N_PREC_ENG) ? ENG_PREC_KHZ : ENG_GEN_KHZ;
    localparam logic [RATIO_W-1:0] R_HPD = RATIO_W'((EKHZ + F_HPDIFF_MAX_KHZ - 1)
                                                    / F_HPDIFF_MAX_KHZ);
    localparam logic [RATIO_W-1:0] R_HPS = RATIO_W'((EKHZ + F_HPSE_MAX_KHZ - 1)
                                                    / F_HPSE_MAX_KHZ);
    localparam logic [RATIO_W-1:0] R_CFS = RATIO_W'((EKHZ + F_CFGSE_MAX_KHZ - 1)
                                                    / F_CFGSE_MAX_KHZ);
    localparam logic [RATIO_W-1:0] R_CFD = RATIO_W'((EKHZ + F_CFGDIFF_MAX_KHZ - 1)
                                                    / F_CFGDIFF_MAX_KHZ);
    localparam logic [RATIO_W-1:0] R_MAX = RATIO_W'(EKHZ / F_MIN_KHZ);

    chan_if cif ();

    wire                diff_bank = bank_diff[ENG / N_BANK];
    wire                is_cfg    = (SUB == SUB_CFG);
    // bank mode picks the driver type of the configurable channel (sub 3) only
    wire                se        = (SUB == SUB_HPSE) || (is_cfg && !diff_bank);
    wire [RATIO_W-1:0]  raw       = ratio_mem[g];
    wire [RATIO_W-1:0]  r_min     = (SUB < SUB_HPSE) ? R_HPD :
                                    !is_cfg          ? R_HPS :
                                    diff_bank        ? R_CFD : R_CFS;
    wire [RATIO_W-1:0]  r_eff     = (raw < r_min) ? r_min :
                                    (raw > R_MAX) ? R_MAX : raw;
    wire [CFGW_W-1:0]   cw        = skew_mem[g];
    wire [PIN_W-1:0]    pin       = cw[SK_PIN_LSB +: PIN_W];
    wire                pin_in    = (pin < PIN_W'(GPIO_W)) ? gpio_live[pin] : 1'b0;
    wire                stop_any  = stop_req[g] || (cw[SK_PEN_BIT] && pin_in);

    assign cif.tick      = synth_tick_i[ENG];
    assign cif.en        = ch_en[g];
    assign cif.stop      = se && stop_any;
    assign cif.edge_rise = stop_rise[g];
    assign cif.ratio     = r_eff;
    assign cif.skew      = se ? cw[SKEW_W-1:0] : '0;
    assign running[g]    = cif.running;

    pdiv_channel u_ch (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .ch    (cif.chan)
    );

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pdiv_clk_o[g]                  <= 1'b0;
        fine_skew_o[g*FINE_W +: FINE_W] <= '0;
      end else if (ce_i) begin
        pdiv_clk_o[g] <= cif.clk_out;
        fine_skew_o[g*FINE_W +: FINE_W] <= (fine_en && se) ? cw[SK_FINE_LSB +: FINE_W] : '0;
      end
    end
  end

endmodule

// file: bench/pdiv_props.sv
`timescale 1ns/1ps
module pdiv_props
  import pdiv_pkg::*;
(
  // watched ports
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   ce_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [ADR_W-1:0]       wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic [N_ENGINE-1:0]    synth_tick_i,
  input wire logic [N_CH-1:0]        pdiv_clk_o,
  input wire logic [N_CH*FINE_W-1:0] fine_skew_o,
  input wire logic [N_BANK-1:0]      bank_diff_o,
  input wire logic                   strap_done_o,
  input wire logic [1:0]             mclk_code_o,
  input wire logic                   mclk_ok_o
);
  // differential channels: sub 0 and 1 of every engine
  localparam logic [63:0] DIFF_MASK = 64'h00ff00ff00ff00ff;
  wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  wire cfg_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (wb_adr_i == REG_OUTCFG) & wb_sel_i[0]
                & ce_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // bus and status
  // ---------------------------------------------------------------
  a_ack_next: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
  a_mclk_sel: assert property (mclk_ok_o == (strap_done_o && mclk_code_o == MCLK_CODE_24M576))
    else $error("master clock flag wrong");
  a_code_hold: assert property (strap_done_o && $past(strap_done_o) |-> $stable(mclk_code_o))
    else $error("strap code moved");
  a_bank_write: assert property (cfg_wr |=> bank_diff_o == $past(wb_dat_i[1:0]))
    else $error("bank mode not taken");
  a_fine_diff: assert property ((fine_skew_o & DIFF_MASK) == 64'h0)
    else $error("fine skew on differential");
  for (genvar e = 0; e < N_ENGINE; e++) begin : g_eng
    a_clk_hold: assert property (!synth_tick_i[e] |=> ##1 $stable(pdiv_clk_o[4*e +: 4]))
      else $error("clock moved without tick");
  end

  c_strap: cover property ($rose(mclk_ok_o));
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_bank: cover property (cfg_wr);
endmodule

bind pdiv_skew_ctrl pdiv_props i_pdiv_props (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .synth_tick_i, .pdiv_clk_o,
  .fine_skew_o, .bank_diff_o, .strap_done_o, .mclk_code_o, .mclk_ok_o);

// file: bench/board_ctl.sv
`timescale 1ns/1ps
module board_ctl
  import pdiv_pkg::*;
#(
  parameter int unsigned POR_CYC = 20,
  parameter int unsigned WIN_CYC = 20
)
(
  // clock
  input  wire logic        clk_i,
  // board pins
  output logic             pwr_n_o,
  output logic [GPIO_W-1:0] gpio_o
);
  initial begin
    pwr_n_o = 1'b0;
    gpio_o  = '0;
  end

  task automatic power_up(input logic [1:0] code);
    @(posedge clk_i);
    pwr_n_o     <= 1'b0;
    gpio_o[1:0] <= code;
    repeat (POR_CYC) @(posedge clk_i);
    pwr_n_o <= 1'b1;
    repeat (WIN_CYC + 12) @(posedge clk_i);
    // released pins no longer show the strap level
    gpio_o[1:0] <= ~code;
  endtask

  task automatic set_pin(input int idx, input logic lvl);
    @(posedge clk_i);
    gpio_o[idx] <= lvl;
  endtask
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import pdiv_pkg::*;
  localparam int WIN = 20;
  logic                   clk_i        = 1'b0;
  logic                   rst_i        = 1'b1;
  logic                   ce_i         = 1'b1;
  logic                   wb_cyc_i     = 1'b0;
  logic                   wb_stb_i     = 1'b0;
  logic                   wb_we_i      = 1'b0;
  logic [ADR_W-1:0]       wb_adr_i     = '0;
  logic [3:0]             wb_sel_i     = 4'hf;
  logic [31:0]            wb_dat_i     = '0;
  logic [N_ENGINE-1:0]    synth_tick_i = 4'hf;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack_o;
  logic                   pwr_n_i;
  logic [GPIO_W-1:0]      gpio_i;
  logic [N_CH-1:0]        pdiv_clk_o;
  logic [N_CH*FINE_W-1:0] fine_skew_o;
  logic [N_BANK-1:0]      bank_diff_o;
  logic [N_SLEW-1:0]      slew_fast_o;
  logic                   strap_done_o;
  logic [1:0]             mclk_code_o;
  logic                   mclk_ok_o;
  int                     error_cnt    = 0;
  int                     tests_run    = 0;

  initial forever #5 clk_i = ~clk_i;

  pdiv_skew_ctrl #(.STRAP_WINDOW_CYCLES(WIN)) i_pdiv_skew_ctrl (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .synth_tick_i,
    .pwr_n_i, .gpio_i, .pdiv_clk_o, .fine_skew_o, .bank_diff_o, .slew_fast_o, .strap_done_o,
    .mclk_code_o, .mclk_ok_o);
  board_ctl #(.WIN_CYC(WIN)) i_board_ctl (.clk_i, .pwr_n_o(pwr_n_i), .gpio_o(gpio_i));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    #1;
  endtask

  task automatic meas(input int ch, output int hi, output int lo);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (pdiv_clk_o[ch] !== 1'b0 && n < 200) begin @(posedge clk_i); n++; end
    while (pdiv_clk_o[ch] !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
    while (pdiv_clk_o[ch] === 1'b1 && n < 200) begin @(posedge clk_i); n++; hi++; end
    while (pdiv_clk_o[ch] === 1'b0 && n < 200) begin @(posedge clk_i); n++; lo++; end
    if (n >= 200) error_cnt++;
  endtask

  // ratio after the per-class lower clamp
  function automatic int eff(int ch, int r, logic diff);
    int mn;
    case (ch % 4)
      0, 1: mn = (ch < 8) ? 2 : 1;
      2: mn = (ch < 8) ? 9 : 5;
      default: mn = diff ? ((ch < 8) ? 5 : 3) : ((ch < 8) ? 10 : 5);
    endcase
    return (r < mn) ? mn : r;
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    results;
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [1:0]  bd;
    int          hi, lo, r, ch, t0, t1;
    int          cc[3] = '{2, 3, 8};
    int          rr[3] = '{2, 2, 1};
    void'($urandom(32'h5464));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_STATUS, 0, q); `CHK("status", 32'h0, q)
    wb(1'b0, REG_RATIO, 0, q); `CHK("ratio", 32'h2, q)
    wb(1'b0, 8'h40, 0, q); `CHK("unmapped", 32'h0, q)
    wr(REG_STATUS, 32'hffffffff);
    wb(1'b0, REG_STATUS, 0, q); `CHK("status_ro", 32'h0, q)
    for (int c = 0; c < 4; c++) begin
      i_board_ctl.power_up(c[1:0]);
      repeat (4) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 0, q); `CHK("strap", {c == 3, c[1:0], 1'b1}, q[3:0])
      `CHK("code_kept", c[1:0], mclk_code_o)
    end
    for (int i = 0; i < 10; i++) begin
      ch = (i < 3) ? cc[i] : $urandom_range(15, 0);
      r = (i < 3) ? rr[i] : $urandom_range(16, 2);
      bd = (i == 1) ? 2'h1 : 2'($urandom_range(3, 0));
      q = {4'h0, 12'($urandom), 14'h0, bd};
      wr(REG_OUTCFG, q);
      `CHK("bank", bd, bank_diff_o)
      `CHK("slew", q[27:16], slew_fast_o)
      wr(REG_CH_SEL, ch);
      wr(REG_RATIO, r);
      wr(REG_CH_EN, 32'h1 << ch);
      meas(ch, hi, lo);
      t0 = eff(ch, r, bd[ch/8]);
      `CHK("high", (t0 + 1) / 2, hi)
      `CHK("low", (t0 < 2) ? 1 : t0 / 2, lo)
      wr(REG_CH_EN, 0);
      repeat (2 * t0 + 4) @(posedge clk_i);
    end
    wr(REG_OUTCFG, 32'h4);
    wr(REG_CH_SEL, 2);
    wr(REG_RATIO, 10);
    wr(REG_SKEW, 32'ha0000);
    repeat (2) @(posedge clk_i);
    `CHK("fine", 4'ha, fine_skew_o[8 +: 4])
    wr(REG_CH_SEL, 6);
    wr(REG_RATIO, 10);
    wr(REG_SKEW, 32'h3);
    wr(REG_CH_EN, 32'h44);
    t0 = -1;
    t1 = -1;
    for (int n = 0; n < 100 && t1 < 0; n++) begin
      @(posedge clk_i);
      if (t0 < 0 && pdiv_clk_o[2] === 1'b1) t0 = n;
      if (pdiv_clk_o[6] === 1'b1) t1 = n;
    end
    `CHK("coarse", 3, t1 - t0)
    repeat (20) @(posedge clk_i) synth_tick_i <= 4'($urandom);
    @(posedge clk_i);
    synth_tick_i <= 4'hf;
    wr(REG_STOP, 32'h40004);
    repeat (15) @(posedge clk_i);
    `CHK("stop_high", 1'b1, pdiv_clk_o[2])
    repeat (10) @(posedge clk_i);
    `CHK("stop_held", 1'b1, pdiv_clk_o[2])
    wr(REG_STOP, 0);
    t0 = 0;
    lo = 0;
    while (pdiv_clk_o[2] === 1'b1 && t0 < 50) begin @(posedge clk_i); t0++; end
    while (pdiv_clk_o[2] === 1'b0 && lo < 50) begin @(posedge clk_i); lo++; end
    `CHK("release_low", 5, lo)
    wr(REG_SKEW, 32'h1500003);
    i_board_ctl.set_pin(5, 1'b1);
    repeat (25) @(posedge clk_i);
    `CHK("pin_stop", 1'b0, pdiv_clk_o[6])
    repeat (5) @(posedge clk_i);
    `CHK("pin_held", 1'b0, pdiv_clk_o[6])
    results;
  end
endmodule
